// [verif/rpid_ep_model.sv]
// endpoint model: sends one legacy line or msi write message per call
// assumes calls start just after a rising edge of clk_i
module rpid_ep_model #(
   parameter logic [51:0] WINDOW_BASE = 52'h0_0000_0000_ABC4,
   parameter logic [15:0] REQ_ID = 16'h1234
) (
   // clock
   input wire logic clk_i,
   // message lines
   output logic msg_valid_o,
   output logic msg_is_mem_wr_o,
   output logic [63:0] msg_addr_o,
   output logic [15:0] msg_payload_o,
   output logic [15:0] msg_req_id_o,
   output logic [1:0] msg_line_o,
   output logic msg_assert_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // message driver
   // ************************************************************
   initial begin
      msg_valid_o = 1'b0;
      msg_is_mem_wr_o = 1'b0;
      msg_addr_o = 64'h0;
      msg_payload_o = 16'h0;
      msg_req_id_o = 16'h0;
      msg_line_o = 2'h0;
      msg_assert_o = 1'b0;
   end
   // one strobe cycle, then fields scrambled so stale values never match
   task automatic send(input logic mem, input logic [15:0] pay, input logic [1:0] ln,
                       input logic as);
      msg_valid_o <= 1'b1;
      msg_is_mem_wr_o <= mem;
      msg_addr_o <= {WINDOW_BASE, 12'h000};
      msg_payload_o <= pay;
      msg_req_id_o <= REQ_ID;
      msg_line_o <= ln;
      msg_assert_o <= as;
      @(posedge clk_i);
      msg_valid_o <= 1'b0;
      msg_addr_o <= ~msg_addr_o;
      msg_payload_o <= ~pay;
      msg_line_o <= ~ln;
      @(posedge clk_i);
   endtask
endmodule

// [verif/tb_top.sv]
// testbench: register accesses and endpoint messages with expected values
// assumes the root-port dma build and the endpoint model beside it
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, ack, valid, mem, as, intx, irq;
   logic [11:0] adr;
   logic [31:0] dat_w, dat_r, vec, dat_ep, ep_q;
   logic [63:0] addr;
   logic [15:0] pay, rid;
   logic [1:0] ln;
   logic [3:0] sel, lanes;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   // ************************************************************
   // clock, timeout and instances
   // ************************************************************
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // generous ceiling: the whole run needs under two hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   rpid_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .msg_valid_i(valid), .msg_is_mem_wr_i(mem), .msg_addr_i(addr), .msg_payload_i(pay),
      .msg_req_id_i(rid), .msg_line_i(ln), .msg_assert_i(as),
      .msi_window_base_i(52'h0_0000_0000_ABC4), .msi_low_vector_output_o(vec),
      .intx_decode_o(intx), .irq_o(irq));
   // endpoint build on the same bus: its header read must come back zero
   rpid_top #(.IS_ROOT_PORT(1'b0), .DMA_VARIANT(1'b0)) uut_ep (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
      .dat_o(dat_ep), .ack_o(), .msg_valid_i(valid), .msg_is_mem_wr_i(mem), .msg_addr_i(addr),
      .msg_payload_i(pay), .msg_req_id_i(rid), .msg_line_i(ln), .msg_assert_i(as),
      .msi_window_base_i(52'h0_0000_0000_ABC4), .msi_low_vector_output_o(),
      .intx_decode_o(), .irq_o());
   rpid_ep_model ep (.clk_i(clk_i), .msg_valid_o(valid), .msg_is_mem_wr_o(mem),
      .msg_addr_o(addr), .msg_payload_o(pay), .msg_req_id_o(rid), .msg_line_o(ln),
      .msg_assert_o(as));
   // ************************************************************
   // access and compare tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // classic cycle: held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= a;
      dat_w <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_r;
      ep_q = dat_ep;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e,
                         input logic [31:0] m);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we} = 3'h0;
      sel = 4'h0;
      lanes = 4'hF;
      adr = 12'h000;
      dat_w = 32'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values and an unmapped place
      rd_chk("line_status", 12'h160, 32'h0, 32'hFFFF_FFFF);
      rd_chk("line_mask", 12'h164, 32'h0, 32'hFFFF_FFFF);
      rd_chk("msi_mask_low", 12'h178, 32'h0, 32'hFFFF_FFFF);
      rd_chk("unmapped", 12'h100, 32'h0, 32'hFFFF_FFFF);
      $display("test reset done");
      // msi head: header then payload twice, write pops whatever the data
      ep.send(1'b1, 16'hAB05, 2'h0, 1'b0);
      rd_chk("header", 12'h158, 32'hC000_1234, 32'hFFFF_FFFF);
      chk("endpoint_header", 32'h0, ep_q);
      rd_chk("payload", 12'h15C, 32'h0000_AB05, 32'hFFFF_FFFF);
      rd_chk("payload_again", 12'h15C, 32'h0000_AB05, 32'hFFFF_FFFF);
      rd_chk("msi_status_low", 12'h170, 32'h0000_0020, 32'hFFFF_FFFF);
      wr(12'h15C, 32'hFFFF_FFFF);
      rd_chk("header_empty", 12'h158, 32'h0, 32'h8000_0000);
      $display("test msi queue done");
      // legacy assert then deassert of line c
      ep.send(1'b0, 16'h0000, 2'h2, 1'b1);
      rd_chk("header_line", 12'h158, 32'hB000_0000, 32'hF800_0000);
      rd_chk("payload_line", 12'h15C, 32'h0, 32'hFFFF_FFFF);
      rd_chk("line_set", 12'h160, 32'h0004_0000, 32'hFFFF_FFFF);
      wr(12'h158, 32'h0);
      ep.send(1'b0, 16'h0000, 2'h2, 1'b0);
      rd_chk("line_clear", 12'h160, 32'h0, 32'hFFFF_FFFF);
      wr(12'h158, 32'h0);
      $display("test legacy done");
      // high vector and write-one-to-clear
      ep.send(1'b1, 16'h0028, 2'h0, 1'b0);
      rd_chk("msi_status_high", 12'h174, 32'h0000_0100, 32'hFFFF_FFFF);
      wr(12'h174, 32'hFFFF_FEFF);
      rd_chk("w1c_zeros", 12'h174, 32'h0000_0100, 32'hFFFF_FFFF);
      wr(12'h174, 32'h0000_0100);
      rd_chk("w1c_one", 12'h174, 32'h0, 32'hFFFF_FFFF);
      wr(12'h15C, 32'h0);
      $display("test msi status done");
      // decode mode: low vectors and line summary through their masks
      wr(12'h180, 32'h1);
      repeat (3) @(posedge clk_i);
      chk("vec_masked", 32'h0, vec);
      wr(12'h178, 32'h0000_0020);
      repeat (3) @(posedge clk_i);
      chk("vec_open", 32'h0000_0020, vec);
      ep.send(1'b0, 16'h0000, 2'h0, 1'b1);
      repeat (3) @(posedge clk_i);
      chk("intx_masked", 32'h0, {31'h0, intx});
      lanes = 4'h3;
      wr(12'h164, 32'h0001_0000);
      rd_chk("line_mask_lane", 12'h164, 32'h0, 32'hFFFF_FFFF);
      lanes = 4'hF;
      wr(12'h164, 32'h0001_0000);
      rd_chk("line_mask_rw", 12'h164, 32'h0001_0000, 32'hFFFF_FFFF);
      chk("intx_open", 32'h1, {31'h0, intx});
      wr(12'h15C, 32'h0);
      $display("test decode done");
      // interrupt: unmasked msi event raises irq, status read clears it
      rd_chk("evt_flush", 12'h184, 32'h0000_000D, 32'hFFFF_FFFF);
      wr(12'h188, 32'h4);
      ep.send(1'b1, 16'h0003, 2'h0, 1'b0);
      repeat (3) @(posedge clk_i);
      chk("irq_set", 32'h1, {31'h0, irq});
      rd_chk("evt_status", 12'h184, 32'h5, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk_i);
      chk("irq_clear", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      complete_run();
   end
endmodule

// [verilog/rpid_irq_queue.sv]
// received-interrupt queue with a registered head word
// assumes DEPTH is a power of two; a push into a full queue is refused
module rpid_irq_queue #(
   parameter int WIDTH = 47,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   output logic full_o,
   // drain side
   input wire logic pop_i,
   output logic [WIDTH-1:0] head_o,
   output logic valid_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
   logic [PW:0] cnt_reg, cnt_next;
   logic [WIDTH-1:0] head_reg, head_next;
   logic push_ok, pop_ok;

   // pointers, count and the show-ahead head word
   always_comb begin
      push_ok = push_i && (cnt_reg != CNT_FULL);
      pop_ok = pop_i && (cnt_reg != '0);
      wr_ptr_next = push_ok ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = pop_ok ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      cnt_next = cnt_reg + (PW+1)'(push_ok) - (PW+1)'(pop_ok);
      // bypass: the array is written at the same edge the head is loaded
      if (push_ok && (wr_ptr_reg == rd_ptr_next)) begin
         head_next = push_data_i;
      end else begin
         head_next = mem[rd_ptr_next];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
         head_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
         head_reg <= head_next;
      end
   end

   // storage array, no reset needed
   always_ff @(posedge clk_i) begin
      if (push_ok) begin
         mem[wr_ptr_reg] <= push_data_i;
      end
   end

   assign full_o = (cnt_reg == CNT_FULL);
   assign valid_o = (cnt_reg != '0);
   assign head_o = head_reg;
endmodule

// [verilog/rpid_pkg.sv]
// root-port interrupt intake and decode: shared constants
// assumes a 32-bit classic wishbone register port with byte addresses
package rpid_pkg;
   // ***********************************************************
   // register byte offsets
   // ***********************************************************
   localparam logic [11:0] RPID_OFS_HEADER = 12'h158;
   localparam logic [11:0] RPID_OFS_PAYLOAD = 12'h15C;
   localparam logic [11:0] RPID_OFS_LINE_STATUS = 12'h160;
   localparam logic [11:0] RPID_OFS_LINE_MASK = 12'h164;
   localparam logic [11:0] RPID_OFS_MSI_STATUS_LOW = 12'h170;
   localparam logic [11:0] RPID_OFS_MSI_STATUS_HIGH = 12'h174;
   localparam logic [11:0] RPID_OFS_MSI_MASK_LOW = 12'h178;
   localparam logic [11:0] RPID_OFS_DECODE_CTRL = 12'h180;
   localparam logic [11:0] RPID_OFS_IRQ_STATUS = 12'h184;
   localparam logic [11:0] RPID_OFS_IRQ_MASK = 12'h188;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int RPID_HDR_VALID_BIT = 31;
   localparam int RPID_HDR_MSI_BIT = 30;
   localparam int RPID_HDR_ASSERT_BIT = 29;
   localparam int RPID_HDR_LINE_LSB = 27;
   localparam int RPID_HDR_ADDR_LSB = 16;
   localparam int RPID_LINE_LSB = 16;
   localparam int RPID_LINES = 4;
   localparam int RPID_MSI_VEC_W = 6;
   localparam int RPID_DECODE_EN_BIT = 0;
   localparam int RPID_WINDOW_LSB = 12;

   // queue entry layout: payload, requester, addr 12:2, line, assert, msi
   localparam int RPID_ENT_PAY_LSB = 0;
   localparam int RPID_ENT_RID_LSB = 16;
   localparam int RPID_ENT_ADR_LSB = 32;
   localparam int RPID_ENT_LINE_LSB = 43;
   localparam int RPID_ENT_ASSERT_BIT = 45;
   localparam int RPID_ENT_MSI_BIT = 46;
   localparam int RPID_ENT_W = 47;

   // software interrupt events
   localparam int RPID_EVT_QUEUED = 0;
   localparam int RPID_EVT_OVERFLOW = 1;
   localparam int RPID_EVT_MSI = 2;
   localparam int RPID_EVT_LINE = 3;
   localparam int RPID_EVT_W = 4;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [31:0] RPID_RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RPID_RST_LINES = 4'h0;
   localparam logic [3:0] RPID_RST_EVT = 4'h0;
endpackage

// [verilog/rpid_sticky_bits.sv]
// sticky bit vector: hardware sets, a clear vector drops bits
// assumes set and clear are synchronous one-cycle requests
module rpid_sticky_bits #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // set and clear requests
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   // held bits
   output logic [WIDTH-1:0] bits_o
);
   logic [WIDTH-1:0] bits_reg;
   logic [WIDTH-1:0] bits_next;

   // set wins so an event landing on a clear is never lost
   always_comb begin
      bits_next = (bits_reg & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bits_reg <= '0;
      end else begin
         bits_reg <= bits_next;
      end
   end

   assign bits_o = bits_reg;
endmodule

// [verilog/rpid_top.sv]
// root-port interrupt intake, queue readout and vector decode
// assumes one 10 MHz clock, synchronous message strobes and wishbone classic
// Operation
// - payload read gives oldest MSI data in bits 15:0, upper bits zero.
// - payload read returns zero when the head entry is a legacy message.
// - reading the payload leaves the head entry in the queue.
// - any write to payload or header pops the head; data ignored.
// - endpoint build returns zero on every register of this block.
// - legacy line status bits 16..19 set on assert, held until deassert.
// - zero line status stays zero until assert; resets to zero.
// - line mask bits 16..19 gate status into summary decode output.
// - line mask resets to zero, blocking every line.
// - low MSI status bit x records receipt of vector x, 0-31.
// - high MSI status bit x records receipt of vector x+32.
// - writing one clears an MSI status bit; zeros leave bits alone.
// - decode mode shows low MSI status on output only where masked in.
// - low MSI mask resets to zero, blocking vectors 0-31.
// - plain bridge build treats line status and mask as reserved.
// - header bit 30 flags MSI, bit 31 flags a valid entry.
// - memory writes inside the 4 KB MSI window are queued as MSI.
module rpid_top
   import rpid_pkg::*;
#(
   parameter bit IS_ROOT_PORT = 1'b1,
   parameter bit DMA_VARIANT = 1'b1,
   parameter int QUEUE_DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // inbound messages from endpoints
   input wire logic msg_valid_i,
   input wire logic msg_is_mem_wr_i,
   input wire logic [63:0] msg_addr_i,
   input wire logic [15:0] msg_payload_i,
   input wire logic [15:0] msg_req_id_i,
   input wire logic [1:0] msg_line_i,
   input wire logic msg_assert_i,
   input wire logic [51:0] msi_window_base_i,
   // decoded outputs
   output logic [31:0] msi_low_vector_output_o,
   output logic intx_decode_o,
   output logic irq_o
);
   // ***********************************************************
   // intake classification
   // ***********************************************************
   logic msi_evt, intx_evt, push;
   logic [RPID_ENT_W-1:0] ent_in, head;
   logic q_valid, q_full, pop;

   // memory writes outside the window are not interrupts
   always_comb begin
      msi_evt = msg_valid_i && msg_is_mem_wr_i &&
                (msg_addr_i[63:RPID_WINDOW_LSB] == msi_window_base_i);
      intx_evt = msg_valid_i && !msg_is_mem_wr_i;
      push = msi_evt || intx_evt;
      ent_in = '0;
      ent_in[RPID_ENT_PAY_LSB +: 16] = msi_evt ? msg_payload_i : 16'h0000;
      ent_in[RPID_ENT_RID_LSB +: 16] = msg_req_id_i;
      ent_in[RPID_ENT_ADR_LSB +: 11] = msi_evt ? msg_addr_i[12:2] : 11'h000;
      ent_in[RPID_ENT_LINE_LSB +: 2] = msi_evt ? 2'h0 : msg_line_i;
      ent_in[RPID_ENT_ASSERT_BIT] = intx_evt && msg_assert_i;
      ent_in[RPID_ENT_MSI_BIT] = msi_evt;
   end

   rpid_irq_queue #(
      .WIDTH(RPID_ENT_W),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(push),
      .push_data_i(ent_in),
      .full_o(q_full),
      .pop_i(pop),
      .head_o(head),
      .valid_o(q_valid)
   );

   // ***********************************************************
   // bus access decode
   // ***********************************************************
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic acc_rd, acc_wr;
   logic [31:0] bmask;
   logic line_regs_ok;

   // one access per request; ack comes one cycle after strobe
   always_comb begin
      acc_rd = cyc_i && stb_i && !ack_reg && !we_i;
      acc_wr = cyc_i && stb_i && !ack_reg && we_i;
      ack_next = cyc_i && stb_i && !ack_reg;
      for (int i = 0; i < 4; i++) begin
         bmask[i*8 +: 8] = {8{sel_i[i]}};
      end
      line_regs_ok = DMA_VARIANT && IS_ROOT_PORT;
   end

   // head is removed by a write; the value written is ignored
   assign pop = acc_wr && ((adr_i == RPID_OFS_PAYLOAD) ||
                           (adr_i == RPID_OFS_HEADER));

   // ***********************************************************
   // control registers
   // ***********************************************************
   logic [RPID_LINES-1:0] line_mask_reg, line_mask_next;
   logic [31:0] msi_mask_reg, msi_mask_next;
   logic decode_en_reg, decode_en_next;
   logic [RPID_EVT_W-1:0] irq_mask_reg, irq_mask_next;

   // byte lanes honoured; reserved bits are never stored
   always_comb begin
      line_mask_next = line_mask_reg;
      msi_mask_next = msi_mask_reg;
      decode_en_next = decode_en_reg;
      irq_mask_next = irq_mask_reg;
      if (acc_wr && line_regs_ok && adr_i == RPID_OFS_LINE_MASK && sel_i[2]) begin
         line_mask_next = dat_i[RPID_LINE_LSB +: RPID_LINES];
      end
      if (acc_wr && adr_i == RPID_OFS_MSI_MASK_LOW) begin
         msi_mask_next = (msi_mask_reg & ~bmask) | (dat_i & bmask);
      end
      if (acc_wr && adr_i == RPID_OFS_DECODE_CTRL && sel_i[0]) begin
         decode_en_next = dat_i[RPID_DECODE_EN_BIT];
      end
      if (acc_wr && adr_i == RPID_OFS_IRQ_MASK && sel_i[0]) begin
         irq_mask_next = dat_i[RPID_EVT_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_mask_reg <= RPID_RST_LINES;
         msi_mask_reg <= RPID_RST_WORD;
         decode_en_reg <= 1'b0;
         irq_mask_reg <= RPID_RST_EVT;
      end else begin
         line_mask_reg <= line_mask_next;
         msi_mask_reg <= msi_mask_next;
         decode_en_reg <= decode_en_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // ***********************************************************
   // status vectors
   // ***********************************************************
   logic [RPID_LINES-1:0] line_set, line_clr, line_stat;
   logic [31:0] msi_lo_set, msi_hi_set, msi_lo_clr, msi_hi_clr;
   logic [31:0] msi_lo_stat, msi_hi_stat;
   logic [RPID_EVT_W-1:0] evt_set, evt_clr, evt_stat;
   logic [RPID_MSI_VEC_W-1:0] vec;

   // vector from payload low bits, marked in the accepting cycle
   always_comb begin
      vec = msg_payload_i[RPID_MSI_VEC_W-1:0];
      msi_lo_set = (msi_evt && !vec[5]) ? (32'h0000_0001 << vec[4:0]) : '0;
      msi_hi_set = (msi_evt && vec[5]) ? (32'h0000_0001 << vec[4:0]) : '0;
      msi_lo_clr = (acc_wr && adr_i == RPID_OFS_MSI_STATUS_LOW) ? dat_i & bmask : '0;
      msi_hi_clr = (acc_wr && adr_i == RPID_OFS_MSI_STATUS_HIGH) ? dat_i & bmask : '0;
      line_set = (intx_evt && msg_assert_i) ? (4'h1 << msg_line_i) : '0;
      line_clr = (intx_evt && !msg_assert_i) ? (4'h1 << msg_line_i) : '0;
      evt_set = '0;
      evt_set[RPID_EVT_QUEUED] = push && !q_full;
      evt_set[RPID_EVT_OVERFLOW] = push && q_full;
      evt_set[RPID_EVT_MSI] = msi_evt;
      evt_set[RPID_EVT_LINE] = intx_evt;
      // reading the event status clears it
      evt_clr = (acc_rd && adr_i == RPID_OFS_IRQ_STATUS) ? '1 : '0;
   end

   rpid_sticky_bits #(.WIDTH(RPID_LINES)) u_line_stat (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(line_set),
      .clr_i(line_clr),
      .bits_o(line_stat)
   );

   rpid_sticky_bits #(.WIDTH(32)) u_msi_lo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(msi_lo_set),
      .clr_i(msi_lo_clr),
      .bits_o(msi_lo_stat)
   );

   rpid_sticky_bits #(.WIDTH(32)) u_msi_hi (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(msi_hi_set),
      .clr_i(msi_hi_clr),
      .bits_o(msi_hi_stat)
   );

   rpid_sticky_bits #(.WIDTH(RPID_EVT_W)) u_evt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(evt_set),
      .clr_i(evt_clr),
      .bits_o(evt_stat)
   );

   // ***********************************************************
   // read mux
   // ***********************************************************
   // endpoint build answers every location with zero
   always_comb begin
      rdata_next = '0;
      if (acc_rd && IS_ROOT_PORT) begin
         unique case (adr_i)
            RPID_OFS_HEADER: begin
               rdata_next[RPID_HDR_VALID_BIT] = q_valid;
               rdata_next[RPID_HDR_MSI_BIT] = q_valid && head[RPID_ENT_MSI_BIT];
               if (q_valid) begin
                  rdata_next[RPID_HDR_ASSERT_BIT] = head[RPID_ENT_ASSERT_BIT];
                  rdata_next[RPID_HDR_LINE_LSB +: 2] = head[RPID_ENT_LINE_LSB +: 2];
                  rdata_next[RPID_HDR_ADDR_LSB +: 11] = head[RPID_ENT_ADR_LSB +: 11];
                  rdata_next[15:0] = head[RPID_ENT_RID_LSB +: 16];
               end
            end
            RPID_OFS_PAYLOAD: begin
               // legacy entries and an empty queue read as zero
               if (q_valid && head[RPID_ENT_MSI_BIT]) begin
                  rdata_next[15:0] = head[RPID_ENT_PAY_LSB +: 16];
               end
            end
            RPID_OFS_LINE_STATUS: begin
               if (line_regs_ok) begin
                  rdata_next[RPID_LINE_LSB +: RPID_LINES] = line_stat;
               end
            end
            RPID_OFS_LINE_MASK: begin
               if (line_regs_ok) begin
                  rdata_next[RPID_LINE_LSB +: RPID_LINES] = line_mask_reg;
               end
            end
            RPID_OFS_MSI_STATUS_LOW: rdata_next = msi_lo_stat;
            RPID_OFS_MSI_STATUS_HIGH: rdata_next = msi_hi_stat;
            RPID_OFS_MSI_MASK_LOW: rdata_next = msi_mask_reg;
            RPID_OFS_DECODE_CTRL: rdata_next[RPID_DECODE_EN_BIT] = decode_en_reg;
            RPID_OFS_IRQ_STATUS: rdata_next[RPID_EVT_W-1:0] = evt_stat;
            RPID_OFS_IRQ_MASK: rdata_next[RPID_EVT_W-1:0] = irq_mask_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   // ***********************************************************
   // decoded outputs
   // ***********************************************************
   logic [31:0] vec_out_reg, vec_out_next;
   logic intx_out_reg, intx_out_next;
   logic irq_reg, irq_next;

   // vector and line decode outputs stay quiet until software enables decode mode; irq_o does not wait on it
   always_comb begin
      vec_out_next = decode_en_reg ? (msi_lo_stat & msi_mask_reg) : '0;
      intx_out_next = decode_en_reg && line_regs_ok &&
                      (|(line_stat & line_mask_reg));
      irq_next = |(evt_stat & irq_mask_reg);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= RPID_RST_WORD;
         vec_out_reg <= RPID_RST_WORD;
         intx_out_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         vec_out_reg <= vec_out_next;
         intx_out_reg <= intx_out_next;
         irq_reg <= irq_next;
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;
   assign msi_low_vector_output_o = vec_out_reg;
   assign intx_decode_o = intx_out_reg;
   assign irq_o = irq_reg;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_payload_msi_data: assert property (
      (acc_rd && adr_i == RPID_OFS_PAYLOAD && q_valid && head[RPID_ENT_MSI_BIT] &&
       IS_ROOT_PORT) |=> (ack_o && dat_o == {16'h0000, $past(head[15:0])}))
      else $error("payload read lost msi data");
   chk_payload_intx_zero: assert property (
      (acc_rd && adr_i == RPID_OFS_PAYLOAD && !head[RPID_ENT_MSI_BIT]) |=> (dat_o == '0))
      else $error("payload read of legacy entry not zero");
   chk_read_keeps_head: assert property (
      (acc_rd && q_valid && !push) |=> (q_valid && $stable(head)))
      else $error("read removed head entry");
   chk_write_pops_head: assert property (
      (acc_wr && (adr_i == RPID_OFS_HEADER || adr_i == RPID_OFS_PAYLOAD) && q_valid && !push)
      |=> (u_queue.cnt_reg == $past(u_queue.cnt_reg) - 1'b1))
      else $error("write did not pop head");
   chk_line_hold_high: assert property (
      (line_stat[0] && !(intx_evt && !msg_assert_i && msg_line_i == 2'h0))
      |=> line_stat[0])
      else $error("line status dropped without deassert");
   chk_line_hold_low: assert property (
      (!line_stat[1] && !(intx_evt && msg_assert_i && msg_line_i == 2'h1))
      |=> !line_stat[1])
      else $error("line status rose without assert");
   chk_msi_vector_set: assert property (
      (msi_evt && !vec[5]) |=> msi_lo_stat[$past(vec[4:0])])
      else $error("msi status bit not set");
   chk_msi_high_set: assert property (
      (msi_evt && vec[5]) |=> msi_hi_stat[$past(vec[4:0])])
      else $error("high msi status bit not set");
   chk_w1c_zero_keep: assert property (
      (acc_wr && adr_i == RPID_OFS_MSI_STATUS_HIGH) |=>
      ((msi_hi_stat & $past(msi_hi_stat & ~(dat_i & bmask)))
       == $past(msi_hi_stat & ~(dat_i & bmask))))
      else $error("write of zero cleared status");
   chk_decode_gate: assert property (
      ##1 ((msi_low_vector_output_o & ~$past(msi_mask_reg & msi_lo_stat)) == 32'h0000_0000 &&
           ($past(decode_en_reg) || msi_low_vector_output_o == 32'h0000_0000)))
      else $error("decoded vector not gated by mask");
   chk_window_queue: assert property (
      (msi_evt && !q_full && !q_valid && !pop) |=> (q_valid && head[RPID_ENT_MSI_BIT]))
      else $error("window write not queued as msi");

   cov_msi_received: cover property (msi_evt ##1 irq_o);
   cov_line_assert: cover property (intx_evt && msg_assert_i ##[1:20] intx_decode_o);
   cov_pop_entry: cover property (pop && q_valid);
   cov_overflow: cover property (push && q_full);
endmodule
